/* File: rtl/sram_port_pkg.sv */
// constants for the latched-address static ram controller
package sram_port_pkg;
    localparam int ADDR_W        = 8;     // 256 words
    localparam int DATA_W        = 4;     // 4-bit shared bus
    localparam int CLK_PERIOD_NS = 10;    // 100 MHz
    // device timing, ns as printed
    localparam int T_ADDR_SETUP_NS  = 10;
    localparam int T_ADDR_HOLD_NS   = 70;
    localparam int T_ACCESS_NS      = 350;
    localparam int T_EN_HIGH_NS     = 150;
    localparam int T_EN_LOW_NS      = 350;
    localparam int T_CYCLE_NS       = 500;
    localparam int T_WR_PULSE_NS    = 350;
    localparam int T_WR_SETUP_NS    = 350;
    localparam int T_WR_DATA_DLY_NS = 180;
    localparam int T_DATA_SETUP_NS  = 170;
    localparam int T_DATA_HOLD_NS   = 0;
    localparam int T_OUT_DIS_NS     = 180;
    // least times round up to cycles, at least one
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int C_ADDR_SETUP  = cyc(T_ADDR_SETUP_NS);
    localparam int C_ADDR_HOLD   = cyc(T_ADDR_HOLD_NS);
    localparam int C_ACCESS      = cyc(T_ACCESS_NS);
    localparam int C_EN_HIGH     = cyc(T_EN_HIGH_NS);
    localparam int C_EN_LOW      = cyc(T_EN_LOW_NS);
    localparam int C_CYCLE       = cyc(T_CYCLE_NS);
    localparam int C_WR_PULSE    = cyc(T_WR_PULSE_NS);
    localparam int C_WR_SETUP    = cyc(T_WR_SETUP_NS);
    localparam int C_WR_DATA_DLY = cyc(T_WR_DATA_DLY_NS);
    localparam int C_DATA_SETUP  = cyc(T_DATA_SETUP_NS);
    localparam int C_DATA_HOLD   = cyc(T_DATA_HOLD_NS);
    localparam int C_OUT_DIS     = cyc(T_OUT_DIS_NS);
    localparam int CNT_W         = 8;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_LOW   = 3'h2,
        ST_HIGH  = 3'h3,
        ST_HOLD  = 3'h4
    } phase_t;
endpackage

/* File: rtl/interval_timer.sv */
// down counter that flags when a programmed interval has run out
`timescale 1ns/10ps
module interval_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst,    // sync reset
    input  wire logic         load,   // restart with value
    input  wire logic [W-1:0] value,  // cycles to count
    output logic              done    // interval elapsed
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         done;
    } tmr_t;
    tmr_t cur;
    tmr_t next_cur;
    // load or count down
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.count = value;
            next_cur.done  = (value == '0);
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - 1'b1;
            next_cur.done  = (cur.count == W'(1));
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '{count: '0, done: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end
    assign done = cur.done;
endmodule

/* File: rtl/cycle_spacer.sv */
// counts cycles since the last enable fall, for cycle-time spacing
`timescale 1ns/10ps
module cycle_spacer #(
    parameter int W   = 8,
    parameter int MIN = 50
) (
    input  wire logic clk,     // system clock
    input  wire logic rst,     // sync reset
    input  wire logic fall,    // enable falls this cycle
    output logic      ready    // spacing met
);
    typedef struct packed {
        logic [W-1:0] since;
    } sp_t;
    sp_t cur;
    sp_t next_cur;
    // saturating count since last fall
    always_comb begin
        next_cur = cur;
        if (fall) begin
            next_cur.since = W'(1);
        end else if (cur.since < W'(MIN)) begin
            next_cur.since = cur.since + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cur.since <= W'(MIN);
        end else begin
            cur <= next_cur;
        end
    end
    assign ready = (cur.since >= W'(MIN));
endmodule

/* File: rtl/latched_address_static_ram_port.sv */
// host controller driving a latched-address 256x4 static ram
`timescale 1ns/10ps
module latched_address_static_ram_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,  // address width
    parameter int DATA_W = sram_port_pkg::DATA_W   // data width
) (
    input  wire logic              clk,         // system clock
    input  wire logic              rst,         // sync reset, high
    input  wire logic              reqValid,    // access request
    input  wire logic              reqWrite,    // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] reqAddr,     // word address
    input  wire logic [DATA_W-1:0] reqData,     // write word
    input  wire logic              retain,      // hold in data retention
    output logic                   reqReady,    // request accepted
    output logic                   rspValid,    // access done pulse
    output logic [DATA_W-1:0]      rspData,     // read word
    output logic                   enableN,     // chip enable, low active
    output logic                   writeN,      // write strobe, low active
    output logic [ADDR_W-1:0]      addrOut,     // address pins
    output logic [DATA_W-1:0]      dqOut,       // data bus drive value
    output logic                   dqOe,        // data bus drive enable
    input  wire logic [DATA_W-1:0] dqIn         // data bus sampled value
);
    localparam int CW = sram_port_pkg::CNT_W;

    typedef struct packed {
        sram_port_pkg::phase_t phase;
        logic                  isWrite;
        logic                  strobeHeld;   // write strobe kept low between writes
        logic                  startWait;    // power-up high-time wait pending
        logic [DATA_W-1:0]     wdata;
        logic                  reqReady;
        logic                  rspValid;
        logic [DATA_W-1:0]     rspData;
        logic                  enableN;
        logic                  writeN;
        logic [ADDR_W-1:0]     addrOut;
        logic [DATA_W-1:0]     dqOut;
        logic                  dqOe;
        logic                  tmrLoad;
        logic [CW-1:0]         tmrValue;
    } ctl_t;

    ctl_t cur;
    ctl_t next_cur;
    logic tmrDone;
    logic spaceOk;
    logic enFall;

    //////////////////////////////////////////////////////////////////////////
    // phase timer and cycle spacing
    interval_timer #(.W(CW)) phaseTimer (
        .clk   (clk),
        .rst   (rst),
        .load  (next_cur.tmrLoad),   // loads on the edge that enters a phase
        .value (next_cur.tmrValue),  // so done is never stale in the phase
        .done  (tmrDone)
    );

    cycle_spacer #(.W(CW), .MIN(sram_port_pkg::C_CYCLE)) fallSpacer (
        .clk   (clk),
        .rst   (rst),
        .fall  (enFall),
        .ready (spaceOk)
    );

    assign enFall = cur.enableN && !next_cur.enableN;

    // timer count helper, minus one for the load cycle
    function automatic logic [CW-1:0] ld(input int c);
        return CW'(c - 1);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // access sequencer
    always_comb begin
        next_cur          = cur;
        next_cur.reqReady = 1'b0;
        next_cur.rspValid = 1'b0;
        next_cur.tmrLoad  = 1'b0;
        unique case (cur.phase)
            sram_port_pkg::ST_IDLE: begin
                if (retain) begin
                    // retention: enable and strobe high, bus released
                    next_cur.enableN    = 1'b1;
                    next_cur.writeN     = 1'b1;
                    next_cur.dqOe       = 1'b0;
                    next_cur.strobeHeld = 1'b0;
                    // restart high-time wait once retention ends
                    next_cur.tmrLoad    = 1'b1;
                    next_cur.tmrValue   = ld(sram_port_pkg::C_EN_HIGH);
                end else if (cur.startWait) begin
                    // first high-time wait after reset, nothing taken meanwhile
                    next_cur.startWait  = 1'b0;
                    next_cur.tmrLoad    = 1'b1;
                    next_cur.tmrValue   = ld(sram_port_pkg::C_EN_HIGH);
                end else if (!cur.writeN && cur.strobeHeld && !(reqValid && reqWrite) && tmrDone) begin
                    // chain of writes ended: release the strobe
                    next_cur.writeN     = 1'b1;
                    next_cur.strobeHeld = 1'b0;
                    next_cur.dqOe       = 1'b0;
                end else if (reqValid && tmrDone && spaceOk && !cur.reqReady) begin
                    // present address before enable falls
                    next_cur.reqReady = 1'b1;
                    next_cur.isWrite  = reqWrite;
                    next_cur.addrOut  = reqAddr;
                    next_cur.wdata    = reqData;
                    next_cur.dqOe     = 1'b0;
                    if (!reqWrite) begin
                        next_cur.writeN     = 1'b1;
                        next_cur.strobeHeld = 1'b0;
                    end else begin
                        // strobe falls before enable: bracketed write
                        next_cur.writeN = 1'b0;
                        next_cur.dqOut  = reqData;
                        next_cur.dqOe   = 1'b1;
                    end
                    next_cur.phase    = sram_port_pkg::ST_SETUP;
                    next_cur.tmrLoad  = 1'b1;
                    next_cur.tmrValue = ld(sram_port_pkg::C_ADDR_SETUP);
                end
            end
            sram_port_pkg::ST_SETUP: begin
                if (tmrDone) begin
                    // enable fall latches address in the device
                    next_cur.enableN  = 1'b0;
                    next_cur.phase    = sram_port_pkg::ST_HOLD;
                    next_cur.tmrLoad  = 1'b1;
                    next_cur.tmrValue = ld(sram_port_pkg::C_ADDR_HOLD);
                end
            end
            sram_port_pkg::ST_HOLD: begin
                // address held steady until hold expires
                if (tmrDone) begin
                    next_cur.phase    = sram_port_pkg::ST_LOW;
                    next_cur.tmrLoad  = 1'b1;
                    // remaining low time covers width, access, pulse, setup
                    next_cur.tmrValue = ld(sram_port_pkg::C_EN_LOW - sram_port_pkg::C_ADDR_HOLD);
                end
            end
            sram_port_pkg::ST_LOW: begin
                if (tmrDone) begin
                    if (!cur.isWrite) begin
                        // sample read word at end of low phase
                        next_cur.rspData = dqIn;
                    end
                    // enable rises while a write keeps strobe low: write data held past rise
                    next_cur.enableN  = 1'b1;
                    next_cur.rspValid = 1'b1;
                    next_cur.phase    = sram_port_pkg::ST_HIGH;
                    next_cur.tmrLoad  = 1'b1;
                    next_cur.tmrValue = ld(sram_port_pkg::C_EN_HIGH);
                end
            end
            sram_port_pkg::ST_HIGH: begin
                // enable high for minimum width before idle
                if (cur.isWrite) begin
                    // keep strobe low for a following write
                    next_cur.strobeHeld = 1'b1;
                end
                if (tmrDone) begin
                    next_cur.phase = sram_port_pkg::ST_IDLE;
                end
            end
            default: begin
                next_cur.phase   = sram_port_pkg::ST_IDLE;
                next_cur.enableN = 1'b1;
                next_cur.dqOe    = 1'b0;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            cur          <= '0;
            cur.phase    <= sram_port_pkg::ST_IDLE;
            cur.enableN  <= 1'b1;
            cur.writeN   <= 1'b1;
            cur.startWait <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign reqReady = cur.reqReady;
    assign rspValid = cur.rspValid;
    assign rspData  = cur.rspData;
    assign enableN  = cur.enableN;
    assign writeN   = cur.writeN;
    assign addrOut  = cur.addrOut;
    assign dqOut    = cur.dqOut;
    assign dqOe     = cur.dqOe;
endmodule

/* File: sim/sram_device_model.sv */
// behavioural model of the latched-address 256x4 static ram
`timescale 1ns/10ps
module sram_device_model #(
    parameter real ACCESS_NS = 349.0  // just inside the bound, so sampling at it never races
) (
    input  wire logic [sram_port_pkg::ADDR_W-1:0] addr,    // address pins
    input  wire logic                             enableN, // chip enable, low active
    input  wire logic                             writeN,  // write strobe, low active
    input  wire logic [sram_port_pkg::DATA_W-1:0] dq,      // resolved bus level
    output logic [sram_port_pkg::DATA_W-1:0]      drv,     // read drive value
    output logic                                  oe       // device drives bus
);
    logic [sram_port_pkg::DATA_W-1:0] mem [256];
    logic [sram_port_pkg::ADDR_W-1:0] lat;
    logic                             valid;
    realtime                          tFall;
    realtime                          tAddr;
    ////////////////////////////////////////////////////////////////
    // preset contents with an address pattern
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[3:0] ^ 4'hA;
        lat = 8'h00;
        valid = 1'b0;
        tFall = -1000.0;
        tAddr = -1000.0;
    end
    // capture at enable fall, spoiled if setup broken; word valid after access
    always @(negedge enableN) begin
        lat = ($realtime - tAddr < sram_port_pkg::T_ADDR_SETUP_NS) ? ~addr : addr;
        tFall = $realtime;
        valid = 1'b0;
        #(ACCESS_NS) valid = !enableN;
    end
    // address moving inside the hold window spoils the latch
    always @(addr) begin
        tAddr = $realtime;
        if (!enableN && $realtime - tFall < sram_port_pkg::T_ADDR_HOLD_NS)
            lat = ~lat;
    end
    // store at whichever of strobe or enable ends the write
    always @(posedge enableN) if (!writeN) mem[lat] = dq;
    always @(posedge writeN) if (!enableN) mem[lat] = dq;
    // drive only while enabled and reading, inverted word before access
    assign oe  = !enableN && writeN;
    assign drv = valid ? mem[lat] : ~mem[lat];
endmodule

/* File: sim/latched_address_static_ram_port_properties.sv */
// pin timing assertions for the ram controller
`timescale 1ns/10ps
module latched_address_static_ram_port_properties #(
    parameter int ADDR_W = 8,  // address width
    parameter int DATA_W = 4   // data width
) (
    input wire logic              clk,      // system clock
    input wire logic              rst,      // sync reset
    input wire logic              retain,   // retention request
    input wire logic              reqReady, // request taken
    input wire logic              rspValid, // access done
    input wire logic              enableN,  // chip enable
    input wire logic              writeN,   // write strobe
    input wire logic [ADDR_W-1:0] addrOut,  // address pins
    input wire logic [DATA_W-1:0] dqOut,    // bus drive value
    input wire logic              dqOe      // bus drive enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // enable low span of one access and high span after it
    sequence low_span;
        !enableN throughout (##34 1);
    endsequence
    sequence high_span;
        enableN throughout (##14 1);
    endsequence
    ////////////////////////////////////////////////////////////////
    en_low_width_a: assert property ($fell(enableN) |-> low_span ##1 enableN)
        else $error("enable low width wrong");
    en_high_width_a: assert property ($rose(enableN) |-> high_span)
        else $error("enable high width too short");
    fall_spacing_a: assert property ($fell(enableN) |=> !$fell(enableN) throughout (##48 1))
        else $error("enable falls too close");
    addr_hold_a: assert property (reqReady |=> $fell(enableN) ##0 ($stable(addrOut) throughout (##7 1)))
        else $error("address not held around enable fall");
    wr_lead_a: assert property ($fell(enableN) && !writeN |-> !$past(writeN) && $past(dqOe))
        else $error("strobe or data late for write");
    wr_bracket_a: assert property ($fell(enableN) && !writeN |->
        (!writeN && dqOe && $stable(dqOut)) throughout (##35 1))
        else $error("write strobe or data dropped early");
    rd_release_a: assert property ($fell(enableN) && writeN |-> (writeN && !dqOe) throughout (##35 1))
        else $error("bus driven during read");
    bus_clash_a: assert property (dqOe |-> !writeN)
        else $error("bus driven with strobe high");
    rsp_timing_a: assert property (rspValid == $rose(enableN))
        else $error("response not at enable rise");
    retain_block_a: assert property (retain |=> !reqReady)
        else $error("request taken in retention");
    startup_wait_a: assert property ($fell(rst) |-> high_span)
        else $error("first access too soon after reset");
endmodule
bind latched_address_static_ram_port latched_address_static_ram_port_properties #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)
) u_props (
    .clk(clk), .rst(rst), .retain(retain), .reqReady(reqReady), .rspValid(rspValid),
    .enableN(enableN), .writeN(writeN), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe)
);

/* File: sim/testbench.sv */
// self-checking bench for the latched-address ram controller
`timescale 1ns/10ps
module testbench;
    logic       clk, rst, reqValid, reqWrite, retain, reqReady, rspValid;
    logic       enableN, writeN, dqOe, devOe;
    logic [7:0] reqAddr, addrOut;
    logic [3:0] reqData, rspData, dqOut, dqIn, devDrv, lastBus, q;
    int         errors, samples_checked, w, n, cyc, lastFall, minGap;
    ////////////////////////////////////////////////////////////////
    latched_address_static_ram_port u_dut (
        .clk(clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqData(reqData), .retain(retain), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .enableN(enableN), .writeN(writeN), .addrOut(addrOut),
        .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
    sram_device_model u_ram (
        .addr(addrOut), .enableN(enableN), .writeN(writeN), .dq(dqIn), .drv(devDrv), .oe(devOe));
    // released bus shows the inverse of its last driven level
    always @(dqOe, dqOut, devOe, devDrv) if (dqOe) lastBus = dqOut; else if (devOe) lastBus = devDrv;
    assign dqIn = dqOe ? dqOut : (devOe ? devDrv : ~lastBus);
    // clock and enable-fall spacing monitor
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if ($fell(enableN) && lastFall >= 0 && cyc - lastFall < minGap) minGap = cyc - lastFall;
        if ($fell(enableN)) lastFall = cyc;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one access: wait for acceptance, then for the response pulse
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] d);
        @(negedge clk);
        reqValid = 1'b1; reqWrite = wr; reqAddr = a; reqData = d;
        w = 0;
        while (reqReady !== 1'b1 && w < 300) begin @(negedge clk); w++; end
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        q = rspData;
        check(n, 8'h24);
    endtask
    task automatic test_startup;
        access(1'b1, 8'h00, 4'h5);
        check(w >= 14, 8'h01);
        $display("test startup done");
    endtask
    task automatic test_write_read;
        logic [7:0] ta [3] = '{8'hFF, 8'h5A, 8'h01};
        logic [3:0] td [3] = '{4'hA, 4'h3, 4'hC};
        for (int i = 0; i < 3; i++) access(1'b1, ta[i], td[i]);
        for (int i = 0; i < 3; i++) begin
            access(1'b0, ta[i], 4'h0);
            check(q, td[i]);
        end
        access(1'b0, 8'h00, 4'h0);
        check(q, 8'h05);
        access(1'b0, 8'hFF, 4'h0);
        check(q, 8'h0A);
        check(minGap >= 50, 8'h01);
        $display("test write read done");
    endtask
    task automatic test_retain;
        logic bad;
        access(1'b1, 8'h10, 4'h9);
        @(negedge clk);
        retain = 1'b1; reqValid = 1'b1; reqWrite = 1'b0; reqAddr = 8'h10;
        bad = 1'b0;
        repeat (60) begin @(negedge clk); bad = bad | (reqReady !== 1'b0) | (enableN !== 1'b1); end
        check(bad, 8'h00);
        check({writeN, dqOe}, 8'h02);
        retain = 1'b0;
        access(1'b0, 8'h10, 4'h0);
        check(w >= 13, 8'h01);
        check(q, 8'h09);
        $display("test retain done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog cuts a hang short
    initial begin
        #40us;
        errors++;
        results();
    end
    initial begin
        // request already raised in reset must still wait out the high time
        rst = 1'b1; reqValid = 1'b1; reqWrite = 1'b1; reqAddr = 8'h00; reqData = 4'h5; retain = 1'b0;
        errors = 0; samples_checked = 0; cyc = 0; lastFall = -1; minGap = 1000; lastBus = 4'h0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        test_startup();
        test_write_read();
        test_retain();
        results();
    end
endmodule
